// ### design/mtf_pkg.sv
// Functional notes
// - after a good frame, hold at least 96 bit times before the next one.
// - after a collision, count the 96 bit gap from carrier sense end.
// - half duplex retries with binary exponential back-off; drop after 16.
// - a collision after 512 bit times is late; drop without retry.
// - received pause loads the pause timer; no normal frame until expiry.
// - a newer pause frame replaces the remaining pause count.
// - while paused only own flow control frames may be sent.
// - start pause frames when free queue space falls to high watermark.
// - stop pause frames when free space recovers to low watermark.
// - discard incoming packets when free space reaches overrun watermark.
// - flow-off frame carries the largest pause time.
// - when resources free up, send a pause frame with zero time.
// - half duplex backpressure uses the same conditions, sending preamble.
// - backpressure carrier drops briefly now and then, then rises again.
// - queued frames suspend backpressure carrier and are sent.
// - with nothing to send, backpressure resumes until release.
// - collision in backpressure skips back-off and reasserts carrier.
package mtf_pkg;
	localparam logic [7:0] OFS_LOW_WM = 8'hb0;
	localparam logic [7:0] OFS_HIGH_WM = 8'hb2;
	localparam logic [7:0] OFS_OVR_WM = 8'hb4;
	localparam logic [7:0] OFS_CTRL = 8'hc0;
	localparam logic [7:0] OFS_STATUS = 8'hc2;
	localparam logic [7:0] OFS_IRQ_STAT = 8'hc4;
	localparam logic [7:0] OFS_IRQ_MASK = 8'hc6;
	// watermarks in bytes of free space
	localparam logic [15:0] RST_LOW_WM = 16'h1400;
	localparam logic [15:0] RST_HIGH_WM = 16'h0c00;
	localparam logic [15:0] RST_OVR_WM = 16'h0100;
	localparam logic [15:0] RST_CTRL = 16'h0000;
	// control bits
	localparam int CTRL_FULL_DUPLEX = 0;
	localparam int CTRL_SPEED_100 = 1;
	localparam int CTRL_FC_EN = 2;
	localparam int CTRL_BP_EN = 3;
	// irq bits
	localparam int IRQ_DROP_EXC = 0;
	localparam int IRQ_DROP_LATE = 1;
	localparam int IRQ_PAUSE_RX = 2;
	localparam int IRQ_FC_ON = 3;
	localparam int IRQ_FC_OFF = 4;
	localparam int IRQ_OVERRUN = 5;
	localparam int IRQ_W = 6;
	// bit time counts in sys_clk cycles: 25 MHz, 100 Mb/s = 4 bits per cycle
	localparam int CLK_MHZ = 25;
	localparam int GAP_BITS = 96;
	localparam int SLOT_BITS = 512;
	localparam int MAX_TRIES = 16;
	localparam int BACKOFF_LIMIT = 10;
	localparam int BITS_PER_CYC_100 = 100 / CLK_MHZ;
	localparam int GAP_CYC_100 = (GAP_BITS + BITS_PER_CYC_100 - 1)
		/ BITS_PER_CYC_100;
	localparam int SLOT_CYC_100 = SLOT_BITS / BITS_PER_CYC_100;
	// 10 Mb/s: 2.5 cycles per bit
	localparam int GAP_CYC_10 = (GAP_BITS * 5 + 1) / 2;
	localparam int SLOT_CYC_10 = SLOT_BITS * 5 / 2;
	localparam logic [15:0] PAUSE_MAX = 16'hffff;
	localparam logic [15:0] PAUSE_ZERO = 16'h0000;
	typedef enum {
		MTF_IDLE, MTF_GAP, MTF_SEND, MTF_BACKOFF, MTF_BP
	} mtf_state_t;
endpackage : mtf_pkg

// ### design/mtf_top.sv
`timescale 1ns/100ps
module mtf_top #(
	parameter int BP_BURST_CYC = 2000,
	parameter int BP_SILENT_CYC = 4
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic irq,
	input wire logic [15:0] rxq_free,
	output logic rxq_drop,
	input wire logic tx_req,
	output logic tx_start,
	input wire logic tx_end,
	output logic tx_drop,
	output logic fc_send,
	output logic [15:0] fc_pause_time,
	input wire logic fc_done,
	input wire logic pause_rx,
	input wire logic [15:0] pause_rx_time,
	input wire logic crs,
	input wire logic col,
	output logic bp_preamble
);
	logic [15:0] low_wm_q;
	logic [15:0] high_wm_q;
	logic [15:0] ovr_wm_q;
	logic [15:0] ctrl_q;
	localparam int IRQ_W_L = mtf_pkg::IRQ_W - 1;
	logic [IRQ_W_L:0] irq_stat_q;
	logic [IRQ_W_L:0] irq_mask_q;
	logic [IRQ_W_L:0] ev;
	logic [2:0] crs_s_q;
	logic [2:0] col_s_q;
	logic crs_f_q;
	logic col_f_q;
	mtf_pkg::mtf_state_t st_q;
	logic [15:0] cnt_q;
	logic [4:0] tries_q;
	logic [15:0] slot_q;
	logic drop_late_q;
	logic [9:0] lfsr_q;
	logic [15:0] pause_q;
	logic [12:0] quant_q;
	logic fc_active_q;
	logic fc_pend_q;
	logic [15:0] fc_val_q;
	logic fc_busy_q;
	logic bp_q;
	logic [15:0] bp_cnt_q;
	logic bp_silent_q;
	logic fdx;
	logic sp100;
	logic [15:0] gap_cyc;
	logic [15:0] slot_cyc;

	assign fdx = ctrl_q[mtf_pkg::CTRL_FULL_DUPLEX];
	assign sp100 = ctrl_q[mtf_pkg::CTRL_SPEED_100];
	assign gap_cyc = sp100 ? 16'(mtf_pkg::GAP_CYC_100) :
		16'(mtf_pkg::GAP_CYC_10);
	assign slot_cyc = sp100 ? 16'(mtf_pkg::SLOT_CYC_100) :
		16'(mtf_pkg::SLOT_CYC_10);

	// random back-off slots: mask lfsr to 2^min(n,10)-1
	function automatic logic [15:0] backoff_slots(input logic [4:0] n,
		input logic [9:0] r);
		logic [9:0] m;
		m = 10'h3ff;
		if (n < 5'(mtf_pkg::BACKOFF_LIMIT)) begin
			m = 10'((11'h001 << n) - 11'h001);
		end
		return {6'h00, r & m};
	endfunction : backoff_slots

	// pin inputs: three stages, a change counts when stage 2 and 3 agree
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			crs_s_q <= 3'h0;
			col_s_q <= 3'h0;
			crs_f_q <= 1'b0;
			col_f_q <= 1'b0;
		end else begin
			crs_s_q <= {crs_s_q[1:0], crs};
			col_s_q <= {col_s_q[1:0], col};
			if (crs_s_q[1] == crs_s_q[2]) begin
				crs_f_q <= crs_s_q[2];
			end
			if (col_s_q[1] == col_s_q[2]) begin
				col_f_q <= col_s_q[2];
			end
		end
	end

	// register writes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			low_wm_q <= mtf_pkg::RST_LOW_WM;
			high_wm_q <= mtf_pkg::RST_HIGH_WM;
			ovr_wm_q <= mtf_pkg::RST_OVR_WM;
			ctrl_q <= mtf_pkg::RST_CTRL;
			irq_mask_q <= '0;
		end else if (reg_wr) begin
			if (reg_addr == mtf_pkg::OFS_LOW_WM) begin
				low_wm_q <= reg_wdata;
			end else if (reg_addr == mtf_pkg::OFS_HIGH_WM) begin
				high_wm_q <= reg_wdata;
			end else if (reg_addr == mtf_pkg::OFS_OVR_WM) begin
				ovr_wm_q <= reg_wdata;
			end else if (reg_addr == mtf_pkg::OFS_CTRL) begin
				ctrl_q <= {12'h000, reg_wdata[3:0]};
			end else if (reg_addr == mtf_pkg::OFS_IRQ_MASK) begin
				irq_mask_q <= reg_wdata[IRQ_W_L:0];
			end
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == mtf_pkg::OFS_LOW_WM) begin
				reg_rdata <= low_wm_q;
			end else if (reg_addr == mtf_pkg::OFS_HIGH_WM) begin
				reg_rdata <= high_wm_q;
			end else if (reg_addr == mtf_pkg::OFS_OVR_WM) begin
				reg_rdata <= ovr_wm_q;
			end else if (reg_addr == mtf_pkg::OFS_CTRL) begin
				reg_rdata <= ctrl_q;
			end else if (reg_addr == mtf_pkg::OFS_STATUS) begin
				reg_rdata <= {11'h000, bp_q, fc_active_q,
					pause_q != 16'h0000, rxq_drop, tx_start};
			end else if (reg_addr == mtf_pkg::OFS_IRQ_STAT) begin
				reg_rdata <= {10'h000, irq_stat_q};
			end else if (reg_addr == mtf_pkg::OFS_IRQ_MASK) begin
				reg_rdata <= {10'h000, irq_mask_q};
			end else begin
				reg_rdata <= 16'h0000;
			end
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// sticky events; a new event beats the read clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_q <= '0;
			irq <= 1'b0;
		end else begin
			if (reg_rd && reg_addr == mtf_pkg::OFS_IRQ_STAT) begin
				irq_stat_q <= ev;
			end else begin
				irq_stat_q <= irq_stat_q | ev;
			end
			irq <= |((irq_stat_q | ev) & irq_mask_q);
		end
	end

	// overrun discard and flow control watermark hysteresis
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxq_drop <= 1'b0;
			fc_active_q <= 1'b0;
		end else begin
			rxq_drop <= rxq_free <= ovr_wm_q;
			if (!fc_active_q && rxq_free <= high_wm_q) begin
				fc_active_q <= 1'b1;
			end else if (fc_active_q && rxq_free >= low_wm_q) begin
				fc_active_q <= 1'b0;
			end
		end
	end

	// pause frame requests toward the frame builder, full duplex only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fc_pend_q <= 1'b0;
			fc_val_q <= mtf_pkg::PAUSE_ZERO;
			fc_busy_q <= 1'b0;
			fc_send <= 1'b0;
			fc_pause_time <= mtf_pkg::PAUSE_ZERO;
		end else begin
			fc_send <= 1'b0;
			if (fdx && ctrl_q[mtf_pkg::CTRL_FC_EN]) begin
				if (ev[mtf_pkg::IRQ_FC_ON]) begin
					fc_pend_q <= 1'b1;
					fc_val_q <= mtf_pkg::PAUSE_MAX;
				end else if (ev[mtf_pkg::IRQ_FC_OFF]) begin
					fc_pend_q <= 1'b1;
					fc_val_q <= mtf_pkg::PAUSE_ZERO;
				end
			end
			if (fc_done) begin
				fc_busy_q <= 1'b0;
			end
			// flow control frames go out even while paused
			if (fc_pend_q && !fc_busy_q && st_q == mtf_pkg::MTF_IDLE
				&& !(ev[mtf_pkg::IRQ_FC_ON] || ev[mtf_pkg::IRQ_FC_OFF])) begin
				fc_send <= 1'b1;
				fc_pause_time <= fc_val_q;
				fc_pend_q <= 1'b0;
				fc_busy_q <= 1'b1;
			end
		end
	end

	// pause timer counting 512-bit quanta
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pause_q <= 16'h0000;
			quant_q <= 13'h0000;
		end else if (pause_rx && fdx) begin
			pause_q <= pause_rx_time;
			quant_q <= 13'h0000;
		end else if (pause_q != 16'h0000) begin
			if (quant_q == 13'(slot_cyc - 16'h0001)) begin
				quant_q <= 13'h0000;
				pause_q <= pause_q - 16'h0001;
			end else begin
				quant_q <= quant_q + 13'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lfsr_q <= 10'h001;
		end else begin
			lfsr_q <= {lfsr_q[8:0], lfsr_q[9] ^ lfsr_q[6]};
		end
	end

	// transmit sequencer: gap, send, back-off and backpressure
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= mtf_pkg::MTF_GAP;
			cnt_q <= 16'h0000;
			tries_q <= 5'h00;
			slot_q <= 16'h0000;
			drop_late_q <= 1'b0;
			tx_start <= 1'b0;
			tx_drop <= 1'b0;
			bp_q <= 1'b0;
			bp_cnt_q <= 16'h0000;
			bp_silent_q <= 1'b0;
			bp_preamble <= 1'b0;
		end else begin
			tx_start <= 1'b0;
			tx_drop <= 1'b0;
			bp_q <= !fdx && ctrl_q[mtf_pkg::CTRL_BP_EN] && fc_active_q;
			case (st_q)
				mtf_pkg::MTF_IDLE: begin
					bp_preamble <= 1'b0;
					if (tx_req && pause_q == 16'h0000 && !fc_busy_q
						&& !fc_pend_q) begin
						st_q <= mtf_pkg::MTF_SEND;
						tx_start <= 1'b1;
						cnt_q <= 16'h0000;
					end else if (bp_q && !tx_req) begin
						st_q <= mtf_pkg::MTF_BP;
						bp_cnt_q <= 16'h0000;
						bp_silent_q <= 1'b0;
					end
				end
				mtf_pkg::MTF_GAP: begin
					// gap restarts while carrier is seen
					if (crs_f_q) begin
						cnt_q <= 16'h0000;
					end else if (cnt_q >= gap_cyc - 16'h0001) begin
						st_q <= mtf_pkg::MTF_IDLE;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				mtf_pkg::MTF_SEND: begin
					cnt_q <= cnt_q + 16'h0001;
					if (col_f_q && !fdx) begin
						// cleared first so that the back-off load below wins
						cnt_q <= 16'h0000;
						slot_q <= 16'h0000;
						if (cnt_q >= slot_cyc) begin
							tx_drop <= 1'b1;
							drop_late_q <= 1'b1;
							tries_q <= 5'h00;
							st_q <= mtf_pkg::MTF_GAP;
						end else if (tries_q == 5'(mtf_pkg::MAX_TRIES - 1)) begin
							tx_drop <= 1'b1;
							drop_late_q <= 1'b0;
							tries_q <= 5'h00;
							st_q <= mtf_pkg::MTF_GAP;
						end else if (bp_q) begin
							tries_q <= tries_q + 5'h01;
							st_q <= mtf_pkg::MTF_GAP;
						end else begin
							tries_q <= tries_q + 5'h01;
							// whole slots here; slot_q counts the cycles
							cnt_q <= backoff_slots(tries_q + 5'h01,
								lfsr_q);
							st_q <= mtf_pkg::MTF_BACKOFF;
						end
					end else if (tx_end) begin
						tries_q <= 5'h00;
						cnt_q <= 16'h0000;
						st_q <= mtf_pkg::MTF_GAP;
					end
				end
				mtf_pkg::MTF_BACKOFF: begin
					// counting slots, not cycles, so long waits cannot wrap
					if (cnt_q == 16'h0000) begin
						st_q <= mtf_pkg::MTF_GAP;
					end else if (slot_q >= slot_cyc - 16'h0001) begin
						slot_q <= 16'h0000;
						cnt_q <= cnt_q - 16'h0001;
					end else begin
						slot_q <= slot_q + 16'h0001;
					end
				end
				mtf_pkg::MTF_BP: begin
					if (!bp_q || tx_req) begin
						bp_preamble <= 1'b0;
						cnt_q <= 16'h0000;
						st_q <= mtf_pkg::MTF_GAP;
					end else if (col_f_q && bp_silent_q) begin
						bp_silent_q <= 1'b0;
						bp_cnt_q <= 16'h0000;
						bp_preamble <= 1'b1;
					end else if (!bp_silent_q) begin
						bp_preamble <= 1'b1;
						if (bp_cnt_q >= 16'(BP_BURST_CYC - 1)) begin
							bp_silent_q <= 1'b1;
							bp_cnt_q <= 16'h0000;
						end else begin
							bp_cnt_q <= bp_cnt_q + 16'h0001;
						end
					end else begin
						bp_preamble <= 1'b0;
						if (bp_cnt_q >= 16'(BP_SILENT_CYC - 1)) begin
							bp_silent_q <= 1'b0;
							bp_cnt_q <= 16'h0000;
						end else begin
							bp_cnt_q <= bp_cnt_q + 16'h0001;
						end
					end
				end
				default: st_q <= mtf_pkg::MTF_IDLE;
			endcase
		end
	end

	// event collection for the status register
	always_comb begin
		ev = '0;
		ev[mtf_pkg::IRQ_DROP_EXC] = tx_drop && !drop_late_q;
		ev[mtf_pkg::IRQ_DROP_LATE] = tx_drop && drop_late_q;
		ev[mtf_pkg::IRQ_PAUSE_RX] = pause_rx && fdx;
		ev[mtf_pkg::IRQ_FC_ON] = !fc_active_q && rxq_free <= high_wm_q;
		ev[mtf_pkg::IRQ_FC_OFF] = fc_active_q && rxq_free >= low_wm_q;
		ev[mtf_pkg::IRQ_OVERRUN] = rxq_free <= ovr_wm_q && !rxq_drop;
	end

	gap_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		tx_end && st_q == mtf_pkg::MTF_SEND && !col_f_q |=> !tx_start [*8])
		else $error("frame started inside the gap");
	pause_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		pause_q != 16'h0000 |-> !tx_start)
		else $error("frame started while paused");
	reload_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		pause_rx && fdx |=> pause_q == $past(pause_rx_time))
		else $error("pause count not replaced");
	fc_on_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!fc_active_q && rxq_free <= high_wm_q |=> fc_active_q)
		else $error("flow control not raised");
	fc_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		fc_active_q && rxq_free >= low_wm_q |=> !fc_active_q)
		else $error("flow control not released");
	overrun_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		rxq_free <= ovr_wm_q |=> rxq_drop)
		else $error("overrun not discarding");
	xoff_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		fc_send && fc_active_q |-> fc_pause_time == mtf_pkg::PAUSE_MAX)
		else $error("flow-off time not maximal");
	bp_tx_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		tx_start |-> !bp_preamble)
		else $error("preamble during own frame");
endmodule : mtf_top

// ### test/mtf_partner.sv
`timescale 1ns/100ps
// medium and transmitter as the block sees them
module mtf_partner (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic tx_start,
	input wire logic fc_send,
	input wire logic [15:0] col_at,
	input wire logic col_kick,
	output logic tx_end,
	output logic fc_done,
	output logic crs,
	output logic col
);
	int cnt;
	int fcnt;
	int ccnt;
	// 300 cycle frame; a collision at col_at cuts it and drops carrier
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 0;
			ccnt <= 0;
			crs <= 1'b0;
			col <= 1'b0;
			tx_end <= 1'b0;
		end else begin
			tx_end <= 1'b0;
			// a collision lasts three cycles so the pin filter keeps it
			col <= ccnt != 0;
			ccnt <= col_kick ? 3 : (ccnt != 0) ? ccnt - 1 : 0;
			if (tx_start) begin
				cnt <= 1;
				crs <= 1'b1;
			end else if (cnt != 0) begin
				cnt <= cnt + 1;
				if (cnt == 300 || cnt == int'(col_at)) begin
					cnt <= 0;
					crs <= 1'b0;
					tx_end <= (cnt == 300);
					if (cnt != 300) ccnt <= 3;
				end
			end
		end
	end
	// a pause frame occupies the wire for eight cycles
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fcnt <= 0;
			fc_done <= 1'b0;
		end else begin
			fc_done <= (fcnt == 8);
			fcnt <= fc_send ? 1 : (fcnt != 0 && fcnt != 8) ? fcnt + 1 : 0;
		end
	end
endmodule : mtf_partner

// ### test/mac_tx_flow_control_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module mac_tx_flow_control_bench;
	logic sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, rxq_free = 16'hffff, rw;
	logic [15:0] reg_rdata, fc_pause_time, col_at = 16'h0000;
	logic [15:0] pause_rx_time = 16'h0000;
	logic irq, rxq_drop, tx_req = 1'b0, tx_start, tx_end, tx_drop, fc_send;
	logic fc_done, pause_rx = 1'b0, crs, col, col_kick = 1'b0, bp_preamble;
	logic rd_seen = 1'b0;
	int err_total = 0, n_tests = 0, gap = 0, starts = 0, drops = 0;
	int s0, d0, n;
	logic [15:0] rd_exp[$], rd_msk[$], fc_exp[$];
	always #20 sys_clk = ~sys_clk;
	mtf_top #(.BP_BURST_CYC(20), .BP_SILENT_CYC(4)) mtf_top_i (
		.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .rxq_free(rxq_free),
		.rxq_drop(rxq_drop), .tx_req(tx_req), .tx_start(tx_start),
		.tx_end(tx_end), .tx_drop(tx_drop), .fc_send(fc_send),
		.fc_pause_time(fc_pause_time), .fc_done(fc_done),
		.pause_rx(pause_rx), .pause_rx_time(pause_rx_time), .crs(crs),
		.col(col), .bp_preamble(bp_preamble));
	mtf_partner mtf_partner_i (.sys_clk(sys_clk), .arst_n(arst_n),
		.tx_start(tx_start), .fc_send(fc_send), .col_at(col_at),
		.col_kick(col_kick), .tx_end(tx_end), .fc_done(fc_done),
		.crs(crs), .col(col));
	// oldest note against each read result and pause frame as it appears
	always @(posedge sys_clk) begin
		logic [15:0] e;
		rd_seen <= reg_rd;
		gap <= crs ? 0 : gap + 1;
		if (tx_drop) drops <= drops + 1;
		if (rd_seen) begin
			e = rd_exp.pop_front();
			`CHK(reg_rdata & rd_msk.pop_front(), e)
		end
		if (fc_send) begin
			if (fc_exp.size() == 0) `CHK(1'b1, 1'b0)
			else begin
				e = fc_exp.pop_front();
				`CHK(fc_pause_time, e)
			end
		end
		if (tx_start) begin
			starts <= starts + 1;
			`CHK(gap >= mtf_pkg::GAP_CYC_100, 1'b1)
		end
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e, m);
		rd_exp.push_back(e & m);
		rd_msk.push_back(m);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : cyc
	// waits a bounded time for a level, then compares it
	task automatic hold(ref logic s, input logic v, input int k);
		while (k > 0 && s !== v) begin
			@(posedge sys_clk);
			k--;
		end
		`CHK(s, v)
	endtask : hold
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	// watchdog: the sequence needs well under 10000 cycles
	initial begin
		#(40 * 20000);
		err_total++;
		finish_test();
	end
	initial begin
		void'($urandom(38));
		cyc(10);
		arst_n <= 1'b1;
		rd(8'hb0, 16'h1400, 16'hffff);
		rd(8'hb2, 16'h0c00, 16'hffff);
		rd(8'hb4, 16'h0100, 16'hffff);
		rd(8'h20, 16'h0000, 16'hffff);
		rw = 16'($urandom());
		wr(8'hb4, rw);
		rd(8'hb4, rw, 16'hffff);
		wr(8'hb4, 16'h0100);
		// full duplex flow control with the fc-on interrupt unmasked
		wr(8'hc0, 16'h0007);
		wr(8'hc6, 16'h0008);
		rd(8'hc4, 16'h0000, 16'h0000);
		fc_exp.push_back(16'hffff);
		rxq_free <= 16'h0c00;
		hold(irq, 1'b1, 60);
		rd(8'hc4, 16'h0008, 16'h0008);
		cyc(2);
		hold(irq, 1'b0, 3);
		rxq_free <= 16'h0c01 + 16'($urandom_range(16'h07fe));
		cyc(100);
		fc_exp.push_back(16'h0000);
		rxq_free <= 16'h1400;
		cyc(60);
		`CHK(fc_exp.size(), 0)
		`CHK(irq, 1'b0)
		fc_exp.push_back(16'hffff);
		rxq_free <= 16'h00ff;
		hold(rxq_drop, 1'b1, 5);
		cyc(60);
		rxq_free <= 16'h0101 + 16'($urandom_range(16'h0aff));
		hold(rxq_drop, 1'b0, 5);
		fc_exp.push_back(16'h0000);
		rxq_free <= 16'hffff;
		cyc(60);
		// long pause, own pause frame still goes, then a short one
		pause_rx <= 1'b1;
		pause_rx_time <= 16'h0100 + 16'($urandom_range(16'h00ff));
		cyc(1);
		pause_rx <= 1'b0;
		tx_req <= 1'b1;
		s0 = starts;
		fc_exp.push_back(16'hffff);
		rxq_free <= 16'h0c00;
		cyc(200);
		`CHK(starts, s0)
		`CHK(fc_exp.size(), 0)
		fc_exp.push_back(16'h0000);
		rxq_free <= 16'hffff;
		cyc(60);
		pause_rx <= 1'b1;
		pause_rx_time <= 16'h0001;
		cyc(1);
		pause_rx <= 1'b0;
		n = 0;
		while (tx_start !== 1'b1 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK(n >= 127 && n < 400, 1'b1)
		cyc(700);
		tx_req <= 1'b0;
		cyc(400);
		// half duplex: early collision retried, late one dropped
		wr(8'hc0, 16'h0002);
		col_at <= 16'(5 + $urandom_range(95));
		tx_req <= 1'b1;
		hold(tx_start, 1'b1, 400);
		cyc(1);
		hold(tx_start, 1'b1, 500);
		col_at <= 16'(140 + $urandom_range(140));
		tx_req <= 1'b0;
		// the retry start is counted one edge later
		cyc(1);
		s0 = starts;
		d0 = drops;
		cyc(500);
		`CHK(drops, d0 + 1)
		`CHK(starts, s0)
		rd(8'hc4, 16'h0002, 16'h0002);
		// backpressure in half duplex
		col_at <= 16'h0000;
		wr(8'hc0, 16'h000a);
		rxq_free <= 16'h0c00;
		hold(bp_preamble, 1'b1, 10);
		n = 0;
		repeat (60) begin
			@(posedge sys_clk);
			n += (bp_preamble === 1'b0);
		end
		`CHK(n >= 4 && n <= 15, 1'b1)
		col_kick <= 1'b1;
		cyc(1);
		col_kick <= 1'b0;
		cyc(6);
		hold(bp_preamble, 1'b1, 6);
		tx_req <= 1'b1;
		hold(tx_start, 1'b1, 60);
		`CHK(bp_preamble, 1'b0)
		cyc(1);
		tx_req <= 1'b0;
		hold(bp_preamble, 1'b1, 340);
		rxq_free <= 16'hffff;
		hold(bp_preamble, 1'b0, 10);
		cyc(20);
		finish_test();
	end
endmodule : mac_tx_flow_control_bench
